// File: include/sfc_pkg.sv
// Purpose: Shared constants and types for the serial flash configuration register block
// Assumes: 50 MHz system clock, serial clock sampled as a plain input
// Notes:   Opcodes not fixed elsewhere are plain defaults and may be changed
package sfc_pkg;

  // Command opcodes
  localparam logic [7:0] OP_WRITE_ENABLE   = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE  = 8'h04;
  localparam logic [7:0] OP_STATUS_READ_LO = 8'h05;
  localparam logic [7:0] OP_STATUS_READ_HI = 8'h35;
  localparam logic [7:0] OP_CONFIG_READ    = 8'h15;
  localparam logic [7:0] OP_STATUS_WRITE   = 8'h01;
  localparam logic [7:0] OP_CONFIG_WRITE   = 8'h11;
  localparam logic [7:0] OP_EXT_READ       = 8'hC8;
  localparam logic [7:0] OP_EXT_WRITE      = 8'h56;

  // Status register fields
  localparam int ST_BUSY   = 0;
  localparam int ST_LATCH  = 1;
  localparam int ST_STATUS_PROTECT_LO   = 7;
  localparam int ST_STATUS_PROTECT_HI   = 8;
  localparam int ST_QE     = 9;
  localparam int ST_CMP    = 14;
  localparam int ST_BP_LSB = 2;
  localparam logic [15:0] STATUS_KEEP_MASK = 16'h8403;
  localparam logic [15:0] STATUS_OTP_MASK  = 16'h3800;
  localparam logic [15:0] STATUS_RESET     = 16'h0000;

  // Configuration register fields
  localparam int CFG_PIN_FUNC = 7;
  localparam int CFG_PAGE_HI  = 4;
  localparam int CFG_PAGE_LO  = 3;
  localparam int CFG_SCHEME   = 2;
  localparam logic [7:0] CFG_WRITE_MASK = 8'h9C;
  localparam logic [7:0] CFG_RESET      = 8'h00;

  // Extended address register fields
  localparam int EXT_DUMMY   = 7;
  localparam int EXT_PATTERN = 3;
  localparam logic [7:0] EXT_WRITE_MASK = 8'h88;
  localparam logic [7:0] EXT_RESET      = 8'h00;

  localparam logic [7:0]  LEARN_PATTERN    = 8'h34;
  localparam logic [3:0]  DUAL_DUMMY_SHORT = 4'h4;
  localparam logic [3:0]  DUAL_DUMMY_LONG  = 4'h8;
  localparam logic [3:0]  QUAD_DUMMY_SHORT = 4'h6;
  localparam logic [3:0]  QUAD_DUMMY_LONG  = 4'hA;
  localparam logic [10:0] PAGE_BYTES_1X    = 11'h100;
  localparam logic [10:0] PAGE_BYTES_2X    = 11'h200;
  localparam logic [10:0] PAGE_BYTES_4X    = 11'h400;

  // Serial bit counts at the last bit of each byte, at chip-select release, and the cap
  localparam logic [4:0] BITS_LAST_OPCODE = 5'h07;
  localparam logic [4:0] BITS_LAST_BYTE0  = 5'h0F;
  localparam logic [4:0] BITS_LAST_BYTE1  = 5'h17;
  localparam logic [4:0] BITS_OPCODE      = 5'h08;
  localparam logic [4:0] BITS_ONE_BYTE    = 5'h10;
  localparam logic [4:0] BITS_TWO_BYTES   = 5'h18;
  localparam logic [4:0] BITS_MAX         = 5'h1F;

  // Self-timed register write cycle
  localparam int CLK_FREQ_MHZ          = 50;
  localparam int REGISTER_WRITE_TIME_US = 5;
  localparam int REG_WRITE_CYCLES      = CLK_FREQ_MHZ * REGISTER_WRITE_TIME_US;
  localparam logic [15:0] WRITE_TIMER_LOAD = 16'(REG_WRITE_CYCLES - 1);

  // Synchroniser reset value: {wp_n, si, sclk, cs_n}
  localparam logic [3:0] PIN_SYNC_RESET = 4'b1001;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_OPCODE  = 2'b01,
    ST_PAYLOAD = 2'b11
  } sfc_state_t;

endpackage : sfc_pkg

// File: core/sfc_pin_sync.sv
// Purpose: Two-flop synchroniser for pins entering the system clock domain
// Assumes: Synchronous active-high reset
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
module sfc_pin_sync #(
  parameter int         WIDTH      = 4,
  parameter logic [3:0] RESET_BITS = 4'b0000
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] stage_one;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge clk)
      begin
        if (reset)
        begin
          stage_one[i] <= RESET_BITS[i];
          pin_sync[i]  <= RESET_BITS[i];
        end
        else
        begin
          stage_one[i] <= pin_in[i];
          pin_sync[i]  <= stage_one[i];
        end
      end
    end
  endgenerate

endmodule : sfc_pin_sync

// File: core/sfc_config_regs.sv
// Purpose: Serial flash status, configuration and extended address register command handling
// Assumes: Serial clock much slower than clk; single-bit command phase on sio_in[0]
// Notes:   Array read/program/erase and protected area decoding live elsewhere
//
// Overview of operation
// R01 - Configuration read is accepted at any time, even during a write cycle.
// R02 - Configuration read drives the register byte on the serial output; upper lines ignored.
// R03 - Config bit 7 picks hold or reset pin; both off when quad enable set.
// R04 - Config bits 4:3 select page size 256, 512 or 1024 bytes; 11 reserved.
// R05 - Page size sets the program buffer load-address wrap point.
// R06 - Page erase covers double page at 01, quadruple page at 10.
// R07 - Config bit 2 picks block-protect scheme or individual lock bits.
// R08 - Individual block lock bits all set to one at power-on and reset.
// R09 - Status and configuration writes need the write latch set first.
// R10 - Status write never changes status bits 15, 10, 1 and 0.
// R11 - Status write only taken when chip select rises after 8 or 16 data bits.
// R12 - One-byte status write clears complement, quad enable and upper protect bits.
// R13 - Chip select rise starts timed cycle; busy set; then busy and latch clear.
// R14 - Hardware-protected mode refuses status register writes.
// R15 - Configuration write takes one byte exactly, then runs a timed busy cycle.
// R16 - Extended register read: opcode on rising edges, data on falling edges, MSB first.
// R17 - Extended bit 7 selects dummy clocks: dual 4 or 8, quad 6 or 10.
// R18 - Extended bit 3 enables the learning pattern 00110100 during dummy cycles.
// R19 - Extended register write needs the write latch and one data byte.
// R20 - Extended register clears to zero at power-up and any reset.
// R21 - Host polls busy before new commands during a write cycle.
// R22 - Status bit 0 is busy, bit 1 latch; 05h reads low, 35h high byte.
// R23 - Lower protect set, upper clear and protect pin low lock status writes.
// R24 - Reserved configuration and extended bits read zero and ignore writes.
`timescale 1ns/100ps
module sfc_config_regs
  import sfc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        soft_reset,
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic [3:0]  sio_in,
  output logic      [3:0]  sio_out,
  output logic      [3:0]  sio_oe_n,
  input  wire logic        wp_n,
  output logic             hold_pin_enable,
  output logic             reset_pin_enable,
  output logic      [10:0] page_wrap_bytes,
  output logic      [10:0] erase_page_bytes,
  output logic             protect_scheme_select,
  output logic             block_locks_all_set,
  output logic             protect_complement,
  output logic      [4:0]  block_protect_field,
  output logic             quad_io_enable,
  output logic      [3:0]  dual_dummy_clocks,
  output logic      [3:0]  quad_dummy_clocks,
  output logic             learning_pattern_enable,
  output logic      [7:0]  learning_pattern,
  output logic             write_busy_flag,
  output logic             write_latch_flag
);

  import sfc_pkg::*;

  logic [3:0]  pins_sync;
  logic        cs_n_s;
  logic        sclk_s;
  logic        si_s;
  logic        wp_n_s;
  logic        cs_n_d;
  logic        sclk_d;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_fall;
  logic        cs_rise;
  sfc_state_t  state;
  logic [4:0]  bit_count;
  logic [7:0]  shift_in;
  logic [7:0]  next_byte;
  logic [7:0]  opcode;
  logic [7:0]  data_byte0;
  logic [7:0]  data_byte1;
  logic [7:0]  read_byte;
  logic [7:0]  next_read_byte;
  logic        next_reading;
  logic        reading;
  logic        driving;
  logic [15:0] status;
  logic [7:0]  config_reg;
  logic [7:0]  ext_reg;
  logic [15:0] timer;
  logic        hw_protected;
  logic        accept_we;
  logic        accept_wd;
  logic        accept_status;
  logic        accept_config;
  logic        accept_ext;
  logic [15:0] status_image;
  logic [15:0] status_new;
  logic [15:0] next_status;
  logic        write_done;

  sfc_pin_sync #(
    .WIDTH      (4),
    .RESET_BITS (PIN_SYNC_RESET)
  ) u_pin_sync (
    .clk      (clk),
    .reset    (reset),
    .pin_in   ({wp_n, sio_in[0], sclk, cs_n}),
    .pin_sync (pins_sync)
  );

  assign cs_n_s    = pins_sync[0];
  assign sclk_s    = pins_sync[1];
  assign si_s      = pins_sync[2];
  assign wp_n_s    = pins_sync[3];
  assign sclk_rise = sclk_s & ~sclk_d & ~cs_n_s;  // R16
  assign sclk_fall = ~sclk_s & sclk_d & ~cs_n_s;  // R16
  assign cs_fall   = ~cs_n_s & cs_n_d;
  assign cs_rise   = cs_n_s & ~cs_n_d;
  assign next_byte = {shift_in[6:0], si_s};

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cs_n_d <= 1'b1;
      sclk_d <= 1'b0;
    end
    else
    begin
      cs_n_d <= cs_n_s;
      sclk_d <= sclk_s;
    end
  end

  // Frame sequencing
  always_ff @(posedge clk)
  begin
    if (reset || cs_rise)
      state <= ST_IDLE;
    else if (cs_fall)
      state <= ST_OPCODE;
    else
    begin
      unique case (state)
        ST_IDLE:    state <= ST_IDLE;
        ST_OPCODE:  if (sclk_rise && bit_count == BITS_LAST_OPCODE) state <= ST_PAYLOAD;
        ST_PAYLOAD: state <= ST_PAYLOAD;
        default:    state <= ST_IDLE;
      endcase
    end
  end

  // Only sio_in[0] is sampled; the upper lines are ignored in single-bit mode
  always_ff @(posedge clk)
  begin
    if (reset || cs_fall)
    begin
      bit_count <= 5'h00;
      shift_in  <= 8'h00;
    end
    else if (sclk_rise && state != ST_IDLE)
    begin
      shift_in <= next_byte;
      if (bit_count != BITS_MAX)
        bit_count <= bit_count + 5'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      opcode     <= 8'h00;
      data_byte0 <= 8'h00;
      data_byte1 <= 8'h00;
    end
    else if (sclk_rise && state != ST_IDLE)
    begin
      if (bit_count == BITS_LAST_OPCODE)
        opcode <= next_byte;
      if (bit_count == BITS_LAST_BYTE0)
        data_byte0 <= next_byte;
      if (bit_count == BITS_LAST_BYTE1)
        data_byte1 <= next_byte;
    end
  end

  // Live busy and latch are merged so status polls see them mid-cycle
  assign status_image = {status[15:2], write_latch_flag, write_busy_flag};  // R22

  always_comb
  begin
    next_reading   = 1'b1;
    next_read_byte = 8'h00;
    unique case (next_byte)
      OP_STATUS_READ_LO: next_read_byte = status_image[7:0];   // R22
      OP_STATUS_READ_HI: next_read_byte = status_image[15:8];  // R22
      OP_CONFIG_READ:    next_read_byte = config_reg;          // R01 R02
      OP_EXT_READ:       next_read_byte = ext_reg;             // R16
      default:           next_reading = 1'b0;
    endcase
  end

  // Read data shifts out on falling serial clock edges, MSB first, repeating
  always_ff @(posedge clk)
  begin
    if (reset || cs_rise)
    begin
      reading   <= 1'b0;
      driving   <= 1'b0;
      read_byte <= 8'h00;
      sio_out   <= 4'h0;
    end
    else if (sclk_rise && state == ST_OPCODE && bit_count == BITS_LAST_OPCODE)
    begin
      reading   <= next_reading;  // R01
      read_byte <= next_read_byte;
    end
    else if (sclk_fall && state == ST_PAYLOAD && reading)
    begin
      driving    <= 1'b1;                              // R02
      sio_out[1] <= read_byte[7];                      // R16
      read_byte  <= {read_byte[6:0], read_byte[7]};    // R16
    end
  end

  // Only the serial output line is ever driven
  assign sio_oe_n = {2'b11, ~driving, 1'b1};  // R02

  assign hw_protected = (~status[ST_STATUS_PROTECT_HI] & status[ST_STATUS_PROTECT_LO] & ~wp_n_s)  // R14 R23
                      | (status[ST_STATUS_PROTECT_HI] & ~status[ST_STATUS_PROTECT_LO]);
  assign write_done   = write_busy_flag && timer == 16'h0000;

  always_comb
  begin
    accept_we     = 1'b0;
    accept_wd     = 1'b0;
    accept_status = 1'b0;
    accept_config = 1'b0;
    accept_ext    = 1'b0;
    if (cs_rise && state == ST_PAYLOAD && !write_busy_flag)  // R21
    begin
      accept_we     = opcode == OP_WRITE_ENABLE && bit_count == BITS_OPCODE;
      accept_wd     = opcode == OP_WRITE_DISABLE && bit_count == BITS_OPCODE;
      accept_status = opcode == OP_STATUS_WRITE && write_latch_flag && !hw_protected  // R09 R14
                   && !(status[ST_STATUS_PROTECT_HI] && status[ST_STATUS_PROTECT_LO])
                   && (bit_count == BITS_ONE_BYTE || bit_count == BITS_TWO_BYTES);    // R11
      accept_config = opcode == OP_CONFIG_WRITE && write_latch_flag                   // R09
                   && bit_count == BITS_ONE_BYTE;                                     // R15
      accept_ext    = opcode == OP_EXT_WRITE && write_latch_flag                      // R19
                   && bit_count == BITS_ONE_BYTE;
    end
  end

  always_comb
  begin
    status_new = {data_byte1, data_byte0};
    if (bit_count == BITS_ONE_BYTE)
    begin
      status_new = {status[15:8], data_byte0};
      status_new[ST_CMP]  = 1'b0;  // R12
      status_new[ST_QE]   = 1'b0;  // R12
      status_new[ST_STATUS_PROTECT_HI] = 1'b0;  // R12
    end
    // Lock bits are one-time: a status write can set them but never clear them; reset clears them
    next_status = (status & STATUS_KEEP_MASK)                          // R10
                | (status_new & ~STATUS_KEEP_MASK & ~STATUS_OTP_MASK)
                | ((status | status_new) & STATUS_OTP_MASK);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      status <= STATUS_RESET;
    else if (accept_status)
      status <= next_status;  // R10
  end

  // Volatile page size bits clear on a software reset; the rest persist
  always_ff @(posedge clk)
  begin
    if (reset)
      config_reg <= CFG_RESET;
    else if (soft_reset)
      config_reg <= config_reg & ~CFG_WRITE_MASK | (config_reg & 8'h84);
    else if (accept_config)
      config_reg <= data_byte0 & CFG_WRITE_MASK;  // R24
  end

  always_ff @(posedge clk)
  begin
    if (reset || soft_reset)
      ext_reg <= EXT_RESET;                    // R20
    else if (accept_ext)
      ext_reg <= data_byte0 & EXT_WRITE_MASK;  // R19 R24
  end

  always_ff @(posedge clk)
  begin
    if (reset || soft_reset)
    begin
      write_busy_flag <= 1'b0;
      timer           <= 16'h0000;
    end
    else if (accept_status || accept_config)
    begin
      write_busy_flag <= 1'b1;  // R13 R15
      timer           <= WRITE_TIMER_LOAD;
    end
    else if (write_done)
      write_busy_flag <= 1'b0;  // R13
    else if (write_busy_flag)
      timer <= timer - 16'h0001;
  end

  // A new enable is refused while busy, so it never meets the end-of-cycle clear
  always_ff @(posedge clk)
  begin
    if (reset || soft_reset)
      write_latch_flag <= 1'b0;
    else if (accept_we)
      write_latch_flag <= 1'b1;  // R09
    else if (accept_wd || write_done)
      write_latch_flag <= 1'b0;  // R13 R15
  end

  // Lock bits are preset here; per-block lock commands are handled elsewhere
  always_ff @(posedge clk)
  begin
    if (reset || soft_reset)
      block_locks_all_set <= 1'b1;  // R08
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      hold_pin_enable         <= 1'b0;
      reset_pin_enable        <= 1'b0;
      page_wrap_bytes         <= PAGE_BYTES_1X;
      erase_page_bytes        <= PAGE_BYTES_1X;
      protect_scheme_select   <= 1'b0;
      protect_complement      <= 1'b0;
      block_protect_field     <= 5'h00;
      quad_io_enable          <= 1'b0;
      dual_dummy_clocks       <= DUAL_DUMMY_SHORT;
      quad_dummy_clocks       <= QUAD_DUMMY_SHORT;
      learning_pattern_enable <= 1'b0;
      learning_pattern        <= 8'h00;
    end
    else
    begin
      hold_pin_enable  <= ~status[ST_QE] & ~config_reg[CFG_PIN_FUNC];  // R03
      reset_pin_enable <= ~status[ST_QE] & config_reg[CFG_PIN_FUNC];   // R03
      unique case ({config_reg[CFG_PAGE_HI], config_reg[CFG_PAGE_LO]})
        2'b01:   page_wrap_bytes <= PAGE_BYTES_2X;  // R04 R05
        2'b10:   page_wrap_bytes <= PAGE_BYTES_4X;  // R04 R05
        default: page_wrap_bytes <= PAGE_BYTES_1X;  // R04 R05
      endcase
      unique case ({config_reg[CFG_PAGE_HI], config_reg[CFG_PAGE_LO]})
        2'b01:   erase_page_bytes <= PAGE_BYTES_2X;  // R06
        2'b10:   erase_page_bytes <= PAGE_BYTES_4X;  // R06
        default: erase_page_bytes <= PAGE_BYTES_1X;
      endcase
      protect_scheme_select   <= config_reg[CFG_SCHEME];  // R07
      protect_complement      <= status[ST_CMP];          // R07
      block_protect_field     <= status[ST_BP_LSB +: 5];  // R07
      quad_io_enable          <= status[ST_QE];
      dual_dummy_clocks       <= ext_reg[EXT_DUMMY] ? DUAL_DUMMY_LONG : DUAL_DUMMY_SHORT;  // R17
      quad_dummy_clocks       <= ext_reg[EXT_DUMMY] ? QUAD_DUMMY_LONG : QUAD_DUMMY_SHORT;  // R17
      learning_pattern_enable <= ext_reg[EXT_PATTERN];                                     // R18
      learning_pattern        <= ext_reg[EXT_PATTERN] ? LEARN_PATTERN : 8'h00;             // R18
    end
  end

endmodule : sfc_config_regs

// File: verification/sfc_host_model.sv
// Purpose: Host serial controller model driving frames into the register block
// Assumes: Serial clock of 160 ns, changed one step after a clk edge
// Notes:   Frames are given left aligned in a 32-bit word
`timescale 1ns/100ps
module sfc_host_model
(
  input  wire logic       clk,
  input  wire logic [3:0] sio_out,
  output logic            cs_n,
  output logic            sclk,
  output wire logic [3:0] sio_in
);
  logic       si;
  logic [2:0] junk;
  // Upper lines are never looked at, so keep them moving
  assign sio_in = {junk, si};
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si   = 1'b0;
    junk = 3'h0;
  end
  always @(posedge clk) junk <= junk + 3'h5;
  task automatic half();
    repeat (4) @(posedge clk);
    #1;
  endtask : half
  task automatic xfer(input logic [31:0] tx, input int nb, input int nr, output logic [7:0] rd);
    rd = 8'h00;
    half();
    cs_n = 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      si = tx[31-i];
      half();
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
    for (int i = 0; i < nr; i++)
    begin
      si = ~si;
      half();
      sclk = 1'b1;
      half();
      rd = {rd[6:0], sio_out[1]};
      sclk = 1'b0;
    end
    half();
    // Release after the last bit given, whole byte or not, clock parked low
    cs_n = 1'b1;
    si = ~si;
    half();
    half();
  endtask : xfer
endmodule : sfc_host_model

// File: verification/sfc_config_regs_sva.sv
// Purpose: Port-level checker for the configuration register block
// Assumes: Single clk domain, synchronous reset
// Notes:   Bound into every instance of the block
`timescale 1ns/100ps
module sfc_regs_chk
  import sfc_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        soft_reset,
  input wire logic        cs_n,
  input wire logic [3:0]  sio_out,
  input wire logic [3:0]  sio_oe_n,
  input wire logic        hold_pin_enable,
  input wire logic        reset_pin_enable,
  input wire logic [10:0] page_wrap_bytes,
  input wire logic [10:0] erase_page_bytes,
  input wire logic        protect_complement,
  input wire logic        quad_io_enable,
  input wire logic        block_locks_all_set,
  input wire logic [3:0]  dual_dummy_clocks,
  input wire logic [3:0]  quad_dummy_clocks,
  input wire logic        learning_pattern_enable,
  input wire logic [7:0]  learning_pattern,
  input wire logic        write_busy_flag,
  input wire logic        write_latch_flag
);
  logic [8:0] busy_cnt;
  always_ff @(posedge clk)
  begin
    if (reset || !write_busy_flag)
      busy_cnt <= 9'h000;
    else
      busy_cnt <= busy_cnt + 9'h001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence cs_quiet;
    cs_n[*8];
  endsequence
  sequence busy_held;
    write_busy_flag[*4];
  endsequence
  a_spare_lines: assert property (sio_oe_n[3] && sio_oe_n[2] && sio_oe_n[0] && sio_out[3:2] == 2'b00 && !sio_out[0])
    else $error("spare serial lines not idle");
  a_oe_idle: assert property (cs_quiet |-> sio_oe_n[1] && !sio_out[1])
    else $error("serial output driven outside a frame");
  a_page_map: assert property ((page_wrap_bytes == 11'h100 || page_wrap_bytes == 11'h200 || page_wrap_bytes == 11'h400)
    && erase_page_bytes == page_wrap_bytes) else $error("page size outputs inconsistent");
  a_dummy_pair: assert property ((dual_dummy_clocks == 4'h4 && quad_dummy_clocks == 4'h6)
    || (dual_dummy_clocks == 4'h8 && quad_dummy_clocks == 4'hA)) else $error("dummy clock pair wrong");
  a_pattern_value: assert property ($stable(learning_pattern_enable) |->
    learning_pattern == (learning_pattern_enable ? 8'h34 : 8'h00)) else $error("learning pattern wrong");
  a_pin_excl: assert property (quad_io_enable[*2] |-> !hold_pin_enable && !reset_pin_enable)
    else $error("hold or reset pin active with quad enable");
  a_busy_start: assert property ($rose(write_busy_flag) |-> write_latch_flag && cs_n)
    else $error("busy began without latch or inside a frame");
  a_busy_length: assert property ($fell(write_busy_flag) && !$past(soft_reset) |-> busy_cnt == 9'(REG_WRITE_CYCLES))
    else $error("write cycle length wrong");
  a_latch_clear: assert property ($fell(write_busy_flag) |-> !write_latch_flag)
    else $error("latch not cleared with busy");
  a_busy_freeze: assert property (busy_held |-> $stable(page_wrap_bytes) && $stable(protect_complement)
    && $stable(quad_io_enable)) else $error("register changed during write cycle");
  a_locks_set: assert property (soft_reset |-> ##[1:2] block_locks_all_set)
    else $error("block locks not set by reset");
  a_ext_clear: assert property (soft_reset |-> ##[1:3] (!learning_pattern_enable && dual_dummy_clocks == 4'h4))
    else $error("extended register not cleared by reset");
endmodule : sfc_regs_chk
bind sfc_config_regs sfc_regs_chk chk_u (.clk(clk), .reset(reset), .soft_reset(soft_reset), .cs_n(cs_n),
  .sio_out(sio_out), .sio_oe_n(sio_oe_n), .hold_pin_enable(hold_pin_enable), .reset_pin_enable(reset_pin_enable),
  .page_wrap_bytes(page_wrap_bytes), .erase_page_bytes(erase_page_bytes), .protect_complement(protect_complement),
  .quad_io_enable(quad_io_enable), .block_locks_all_set(block_locks_all_set), .dual_dummy_clocks(dual_dummy_clocks),
  .quad_dummy_clocks(quad_dummy_clocks), .learning_pattern_enable(learning_pattern_enable),
  .learning_pattern(learning_pattern), .write_busy_flag(write_busy_flag), .write_latch_flag(write_latch_flag));

// File: verification/sfc_config_regs_bench.sv
// Purpose: Self-checking bench for the configuration register block
// Assumes: Host model owns the serial pins; bench owns reset and write protect
// Notes:   Random data from a fixed-seed shift register
`timescale 1ns/100ps
module sfc_config_regs_bench;
  import sfc_pkg::*;
  logic        clk, reset, soft_reset, wp_n, cs_n, sclk, hold_pin_enable, reset_pin_enable;
  logic        protect_scheme_select, block_locks_all_set, protect_complement, quad_io_enable;
  logic        learning_pattern_enable, write_busy_flag, write_latch_flag;
  logic [3:0]  sio_in, sio_out, sio_oe_n, dual_dummy_clocks, quad_dummy_clocks;
  logic [10:0] page_wrap_bytes, erase_page_bytes;
  logic [4:0]  block_protect_field;
  logic [7:0]  learning_pattern, rd, d, cfg;
  logic [15:0] rnd, st;
  int          bad_count, n_checks;
  sfc_config_regs dut_u (.clk(clk), .reset(reset), .soft_reset(soft_reset), .cs_n(cs_n), .sclk(sclk),
    .sio_in(sio_in), .sio_out(sio_out), .sio_oe_n(sio_oe_n), .wp_n(wp_n), .hold_pin_enable(hold_pin_enable),
    .reset_pin_enable(reset_pin_enable), .page_wrap_bytes(page_wrap_bytes), .erase_page_bytes(erase_page_bytes),
    .protect_scheme_select(protect_scheme_select), .block_locks_all_set(block_locks_all_set),
    .protect_complement(protect_complement), .block_protect_field(block_protect_field),
    .quad_io_enable(quad_io_enable), .dual_dummy_clocks(dual_dummy_clocks), .quad_dummy_clocks(quad_dummy_clocks),
    .learning_pattern_enable(learning_pattern_enable), .learning_pattern(learning_pattern),
    .write_busy_flag(write_busy_flag), .write_latch_flag(write_latch_flag));
  sfc_host_model host_u (.clk(clk), .sio_out(sio_out), .cs_n(cs_n), .sclk(sclk), .sio_in(sio_in));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // Status after a completed write: busy and latch read back clear
  function automatic logic [15:0] exp_st(input logic [15:0] o, input logic [15:0] n, input bit two);
    logic [15:0] v;
    v = (n & 16'h07FC & ~16'h0400) | (n & 16'h4300) | (o & 16'h8400) | ((o | n) & 16'h3800);
    if (!two)
      v[15:8] = {o[15], 1'b0, o[13:10], 2'b00};
    return {v[15:2], 2'b00};
  endfunction : exp_st
  function automatic logic [10:0] exp_pg(input logic [1:0] m);
    return (m == 2'b01) ? 11'h200 : (m == 2'b10) ? 11'h400 : 11'h100;
  endfunction : exp_pg
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic xf(input logic [31:0] tx, input int nb);
    host_u.xfer(tx, nb, (nb == 8 && tx[31:24] != OP_WRITE_ENABLE && tx[31:24] != OP_WRITE_DISABLE) ? 8 : 0, rd);
  endtask : xf
  task automatic wait_idle();
    int k;
    k = 0;
    rd = 8'h01;
    while (rd[0] !== 1'b0 && k < 12)
    begin
      xf({OP_STATUS_READ_LO, 24'h0}, 8);
      k++;
    end
    if (rd[0] !== 1'b0)
    begin
      bad_count++;
      tally_and_finish();
    end
  endtask : wait_idle
  task automatic st_write(input logic [15:0] v, input bit two);
    xf({OP_WRITE_ENABLE, 24'h0}, 8);
    xf({OP_STATUS_WRITE, v[7:0], v[15:8], 8'h00}, two ? 24 : 16);
    chk(write_busy_flag, 1'b1);
    wait_idle();
    st = exp_st(st, v, two);
    xf({OP_STATUS_READ_LO, 24'h0}, 8);
    chk(rd, st[7:0]);
    xf({OP_STATUS_READ_HI, 24'h0}, 8);
    chk(rd, st[15:8]);
    chk({protect_complement, quad_io_enable, block_protect_field}, {st[14], st[9], st[6:2]});
  endtask : st_write
  initial
  begin
    reset = 1'b1;
    soft_reset = 1'b0;
    wp_n = 1'b1;
    rnd = 16'h0039;
    st = 16'h0000;
    bad_count = 0;
    n_checks = 0;
    repeat (2) @(posedge clk);
    #1;
    reset = 1'b0;
    chk(block_locks_all_set, 1'b1);
    xf({OP_EXT_READ, 24'h0}, 8);
    chk(rd, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      d = {rnd[7:5], i[1:0], rnd[2:0]};
      cfg = d & 8'h9C;
      xf({OP_WRITE_ENABLE, 24'h0}, 8);
      xf({OP_CONFIG_WRITE, d, 16'h0}, 16);
      chk(write_busy_flag, 1'b1);
      xf({OP_CONFIG_READ, 24'h0}, 8);
      chk(rd, cfg);
      wait_idle();
      chk(write_latch_flag, 1'b0);
      chk(page_wrap_bytes, exp_pg(i[1:0]));
      chk(erase_page_bytes, exp_pg(i[1:0]));
      chk({protect_scheme_select, hold_pin_enable, reset_pin_enable}, {d[2], ~d[7], d[7]});
    end
    for (int i = 0; i < 3; i++)
    begin
      rnd = lfsr(rnd);
      st_write((rnd & 16'hC67F) | 16'h4200, i != 2);
    end
    st_write(16'h0080, 1'b1);
    wp_n = 1'b0;
    xf({OP_WRITE_ENABLE, 24'h0}, 8);
    xf({OP_STATUS_WRITE, 24'h7C_0000}, 24);
    chk(write_busy_flag, 1'b0);
    xf({OP_STATUS_WRITE, 24'hFF_F000}, 20);
    xf({OP_STATUS_READ_LO, 24'h0}, 8);
    chk(rd, st[7:0] | 8'h02);
    wp_n = 1'b1;
    st_write(16'h0000, 1'b1);
    xf({OP_WRITE_ENABLE, 24'h0}, 8);
    xf({OP_CONFIG_WRITE, ~cfg & 8'h9C, 16'h0}, 24);
    xf({OP_WRITE_DISABLE, 24'h0}, 8);
    xf({OP_CONFIG_WRITE, ~cfg & 8'h9C, 16'h0}, 16);
    xf({OP_EXT_WRITE, 24'h88_0000}, 16);
    xf({OP_CONFIG_READ, 24'h0}, 8);
    chk(rd, cfg);
    xf({OP_EXT_READ, 24'h0}, 8);
    chk(rd, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      rnd = lfsr(rnd);
      d = {i[0], rnd[6:4], i[0], rnd[2:0]};
      xf({OP_WRITE_ENABLE, 24'h0}, 8);
      xf({OP_EXT_WRITE, d, 16'h0}, 16);
      xf({OP_EXT_READ, 24'h0}, 8);
      chk(rd, d & 8'h88);
      chk({dual_dummy_clocks, quad_dummy_clocks}, (i == 1) ? 8'h8A : 8'h46);
      chk(learning_pattern, (i == 1) ? 8'h34 : 8'h00);
    end
    @(posedge clk);
    #1;
    soft_reset = 1'b1;
    @(posedge clk);
    #1;
    soft_reset = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk({block_locks_all_set, write_latch_flag}, 2'b10);
    xf({OP_EXT_READ, 24'h0}, 8);
    chk(rd, 8'h00);
    tally_and_finish();
  end
endmodule : sfc_config_regs_bench
